//--- test/stlm_master.sv
// Motion master model that issues one-cycle motion commands
`timescale 1ns/1ps
`default_nettype none
module stlm_master
(
  input  wire logic        clock,      // Control clock
  input  wire logic        rstn,       // Async reset, active low
  input  wire logic        go,         // Request one command
  input  wire logic [31:0] tgt,        // Target for that command
  output logic             cmd_valid,  // Command pulse
  output logic [31:0]      cmd_target  // Target, scrambled when idle
);
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      cmd_valid  <= 1'b0;
      cmd_target <= 32'h0000_0000;
    end
    else
    begin
      // The bench may ask for more motion while an error is still pending
      cmd_valid  <= go;
      // Idle target flips every cycle so a stale value never looks valid
      cmd_target <= go ? tgt : ~cmd_target;
    end
endmodule : stlm_master
`default_nettype wire

//--- test/stlm_top_tb.sv
// Self-checking testbench for the software travel limit monitor
`timescale 1ns/1ps
`default_nettype none
module stlm_top_tb;
  import stlm_pkg::*;
  logic [7:0]  s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, home_pos, pos_set, pos_act, sensor_dist, cmd_target, home_reference, tgt, rs;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp, react, cur_react;
  logic        clock, rstn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready, s_arvalid, s_arready;
  logic        s_rvalid, s_rready, energized, homing_busy, homing_done, multiturn, cmd_valid, cmd_accept;
  logic        cmd_reject, err_pending, dir_lock, go, power;
  logic [15:0] err_code;
  logic [8:0]  home_adjust;
  logic [33:0] rq[$];
  logic [20:0] cq[$];
  logic [1:0]  bq[$];
  int          miscompares, total_checks, n;
  localparam logic [31:0] REFP = 32'h0000_0110;

  stlm_top DUT (.*);
  stlm_master PARTNER (.*);

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : xs

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  task automatic hang();
    miscompares++;
    test_done();
  endtask : hang

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic aw_p, w_p;
    @(posedge clock);
    bq.push_back(e);
    s_awaddr  <= a;
    s_wdata   <= d;
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    aw_p = 1'b1;
    w_p  = 1'b1;
    n = 0;
    // Each channel is released only at its own handshake edge
    while ((aw_p || w_p) && n < 50)
    begin
      @(posedge clock);
      n++;
      if (aw_p && s_awready === 1'b1)
      begin
        s_awvalid <= 1'b0;
        aw_p = 1'b0;
      end
      if (w_p && s_wready === 1'b1)
      begin
        s_wvalid <= 1'b0;
        w_p = 1'b0;
      end
    end
    if (aw_p || w_p) hang();
    n = 0;
    while (s_bvalid !== 1'b1 && ++n < 50) @(posedge clock);
    if (s_bvalid !== 1'b1) hang();
    s_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [1:0] e, input logic [31:0] d);
    @(posedge clock);
    rq.push_back({e, d});
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    n = 0;
    do @(posedge clock); while (s_arready !== 1'b1 && ++n < 50);
    if (s_arready !== 1'b1) hang();
    s_arvalid <= 1'b0;
    n = 0;
    while (s_rvalid !== 1'b1 && ++n < 50) @(posedge clock);
    if (s_rvalid !== 1'b1) hang();
    s_rready <= 1'b0;
  endtask : rd

  // Expected result is queued; the monitor below compares it
  task automatic cmd(input logic [31:0] t, input logic acc, input logic pend, input logic [15:0] code);
    @(posedge clock);
    go  <= 1'b1;
    tgt <= t;
    cq.push_back({acc, ~acc, pend, pend ? cur_react : 2'h0, code});
    @(posedge clock);
    go <= 1'b0;
    repeat (3) @(posedge clock);
    if (cq.size() != 0) hang();
  endtask : cmd

  task automatic mv(input logic [31:0] p);
    @(posedge clock);
    pos_set <= REFP + p;
  endtask : mv

  task automatic st(input logic p, input logic l, input logic [15:0] c);
    repeat (3) @(posedge clock);
    chk({16'h0, err_pending, dir_lock, err_code}, {16'h0, p, l, c});
  endtask : st

  always @(posedge clock)
    if (s_rvalid === 1'b1 && s_rready === 1'b1)
      chk({s_rresp, s_rdata}, rq.pop_front());

  always @(posedge clock)
    if (s_bvalid === 1'b1 && s_bready === 1'b1)
      chk({32'h0, s_bresp}, {32'h0, bq.pop_front()});

  always @(posedge clock)
    if (cmd_accept === 1'b1 || cmd_reject === 1'b1)
      chk({13'h0, cmd_accept, cmd_reject, err_pending, react, err_code}, {13'h0, cq.pop_front()});

  // Axis jitters while powered; power and position switch on one edge so no stale jitter is monitored
  always @(posedge clock)
  begin
    energized <= power;
    pos_act   <= power ? xs() : REFP;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    rs = 32'h8;
    {s_awaddr, s_araddr, s_wdata, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {homing_busy, homing_done, multiturn, go, tgt, home_pos} = '0;
    s_wstrb = 4'hf;
    power = 1'b1;
    pos_set = REFP;
    sensor_dist = xs();
    cur_react = 2'h2;
    rstn = 1'b0;
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    rd(OFS_CTRL, RESP_OK, 32'h6);
    rd(OFS_ADJ, RESP_OK, 32'h0);
    rd(OFS_WIN, RESP_OK, 32'ha);
    rd(8'h28, RESP_ERR, 32'h0);
    wr(8'h28, 32'h1, RESP_ERR);
    wr(OFS_STAT, 32'h1f, RESP_OK);
    rd(OFS_STAT, RESP_OK, 32'h0);
    rd(OFS_DIST, RESP_OK, sensor_dist);
    wr(OFS_LNEG, 32'hffff_ff9c, RESP_OK);
    wr(OFS_LPOS, 32'h64, RESP_OK);
    cmd(32'd500, 1'b1, 1'b0, 16'h0);
    wr(OFS_HOFS, 32'h10, RESP_OK);
    home_pos <= 32'h100;
    homing_done <= 1'b1;
    @(posedge clock);
    homing_done <= 1'b0;
    wr(OFS_HOFS, 32'hffff_fff0, RESP_OK);
    rd(OFS_REF, RESP_OK, REFP);
    rd(OFS_REF, RESP_OK, REFP);
    chk({2'h0, home_reference}, {2'h0, REFP});
    wr(OFS_ADJ, 32'hc8, RESP_OK);
    rd(OFS_ADJ, RESP_OK, 32'hb4);
    chk({25'h0, home_adjust}, 34'h0b4);
    wr(OFS_ADJ, 32'hffff_ff38, RESP_OK);
    rd(OFS_ADJ, RESP_OK, 32'hffff_ff4c);
    chk({25'h0, home_adjust}, 34'h14c);
    homing_busy <= 1'b1;
    cmd(32'd500, 1'b1, 1'b0, 16'h0);
    homing_busy <= 1'b0;
    cmd(32'd50, 1'b1, 1'b0, 16'h0);
    for (int r = 0; r < 3; r++)
    begin
      cur_react = r[1:0];
      wr(OFS_CTRL, 32'h4 | r, RESP_OK);
      cmd(32'd101, 1'b0, 1'b1, CODE_POS);
      cmd(32'hffff_ff38, 1'b0, 1'b1, CODE_POS);
      wr(OFS_CTRL, 32'h104 | r, RESP_OK);
      st(1'b0, 1'b0, CODE_POS);
    end
    cmd(32'hffff_ff9b, 1'b0, 1'b1, CODE_NEG);
    wr(OFS_CTRL, 32'h106, RESP_OK);
    mv(32'd150);
    st(1'b1, 1'b0, CODE_POS);
    wr(OFS_CTRL, 32'h106, RESP_OK);
    st(1'b0, 1'b1, CODE_POS);
    cmd(32'd50, 1'b1, 1'b0, CODE_POS);
    cmd(32'd200, 1'b0, 1'b1, CODE_POS);
    wr(OFS_CTRL, 32'h106, RESP_OK);
    mv(32'd95);
    st(1'b0, 1'b0, CODE_POS);
    mv(32'd105);
    st(1'b0, 1'b0, CODE_POS);
    mv(32'd50);
    mv(32'd105);
    st(1'b1, 1'b0, CODE_POS);
    wr(OFS_CTRL, 32'h106, RESP_OK);
    mv(32'h0);
    mv(32'hffff_ff6a);
    st(1'b1, 1'b0, CODE_NEG);
    wr(OFS_CTRL, 32'h106, RESP_OK);
    mv(32'h0);
    st(1'b0, 1'b0, CODE_NEG);
    power <= 1'b0;
    mv(32'd500);
    st(1'b0, 1'b0, CODE_NEG);
    mv(32'h0);
    power <= 1'b1;
    wr(OFS_CTRL, 32'h36, RESP_OK);
    cmd(32'd101, 1'b0, 1'b1, CODE_POS);
    wr(OFS_CTRL, 32'h116, RESP_OK);
    cmd(32'd500, 1'b1, 1'b0, CODE_POS);
    wr(OFS_CTRL, 32'h26, RESP_OK);
    mv(32'd50);
    cmd(32'd60, 1'b0, 1'b1, CODE_POS);
    wr(OFS_CTRL, 32'h126, RESP_OK);
    cmd(32'd40, 1'b1, 1'b0, CODE_POS);
    mv(32'h0);
    wr(OFS_CTRL, 32'h2, RESP_OK);
    cmd(32'd500, 1'b1, 1'b0, CODE_POS);
    mv(32'd150);
    st(1'b0, 1'b0, CODE_POS);
    @(posedge clock);
    rstn <= 1'b0;
    multiturn <= 1'b1;
    pos_set <= 32'h0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    cmd(32'd1, 1'b0, 1'b1, CODE_POS);
    if (rq.size() != 0 || bq.size() != 0) hang();
    test_done();
  end
endmodule : stlm_top_tb
`default_nettype wire

//--- verilog/stlm_pkg.sv
// Package for the software travel limit monitor: register map, fields, reset values, types
`default_nettype none
package stlm_pkg;

  localparam int unsigned PW = 32;
  localparam int unsigned AW = 8;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AW-1:0] OFS_ADJ  = 8'h04;
  localparam logic [AW-1:0] OFS_HOFS = 8'h08;
  localparam logic [AW-1:0] OFS_LNEG = 8'h0c;
  localparam logic [AW-1:0] OFS_LPOS = 8'h10;
  localparam logic [AW-1:0] OFS_WIN  = 8'h14;
  localparam logic [AW-1:0] OFS_STAT = 8'h18;
  localparam logic [AW-1:0] OFS_CODE = 8'h1c;
  localparam logic [AW-1:0] OFS_REF  = 8'h20;
  localparam logic [AW-1:0] OFS_DIST = 8'h24;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_REACT_LSB = 0;
  localparam int CTRL_EN_BIT    = 2;
  localparam int CTRL_MODE_LSB  = 4;
  localparam int CTRL_ACK_BIT   = 8;
  localparam int ST_PEND        = 0;
  localparam int ST_LOCK        = 1;
  localparam int ST_LOCKPOS     = 2;
  localparam int ST_ACTIVE      = 3;
  localparam int ST_HOMED       = 4;

  // ****************************************
  // Values and reset values
  // ****************************************
  localparam logic [15:0]        CODE_POS = 16'h7323;
  localparam logic [15:0]        CODE_NEG = 16'h7324;
  localparam logic signed [8:0]  ADJ_MIN  = 9'sh14c;
  localparam logic signed [8:0]  ADJ_MAX  = 9'sh0b4;
  localparam logic signed [8:0]  ADJ_RST  = 9'sh000;
  localparam logic [PW-1:0]      HOFS_RST = 32'h0000_0000;
  localparam logic [PW-1:0]      LNEG_RST = 32'h0000_0000;
  localparam logic [PW-1:0]      LPOS_RST = 32'h0000_0000;
  localparam logic [PW-1:0]      WIN_RST  = 32'h0000_000a;
  localparam logic [1:0]         RESP_OK  = 2'h0;
  localparam logic [1:0]         RESP_ERR = 2'h2;

  typedef enum logic [1:0] {
    REACT_NONE = 2'b00,
    REACT_STOP = 2'b01,
    REACT_OFF  = 2'b10
  } stlm_react_t;

  typedef enum logic [1:0] {
    MODE_ABS   = 2'b00,
    MODE_RESET = 2'b01,
    MODE_CONT  = 2'b10
  } stlm_mode_t;

  typedef struct packed {
    stlm_react_t react;
    logic        err_en;
    stlm_mode_t  mode;
  } stlm_cfg_t;

  localparam stlm_cfg_t CFG_RST = '{react: REACT_OFF, err_en: 1'b1, mode: MODE_ABS};

endpackage : stlm_pkg
`default_nettype wire

//--- verilog/stlm_top.sv
// Software travel limit monitor with AXI4-Lite register slave
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Home adjust angle clamped to -180..180, default 0
// - Reference point equals home position plus offset
// - New offset applies only after next homing
// - Reaction: none, ramp stop, ramp de-energize (default)
// - Absolute mode refuses targets outside limit window
// - Reset mode performs no limit checking
// - Continuous mode checks move relative to position
// - Check setpoint energized, actual position de-energized
// - Re-arm only beyond hysteresis of window size
// - Codes 0x7323 positive, 0x7324 negative
// - Setting enables or disables limit error
// - Limits inactive until homed, referenced to reference
// - No monitoring while homing runs
// - Multiturn encoder enables limits from power-up
// - Errors disabled: every command is allowed
// - Error stays pending until master acknowledges
// - After ack, moves toward window execute silently
// - Locked moves away are blocked and error
// - Status shows home sensor to zero distance
module stlm_top
  import stlm_pkg::*;
(
  input  wire logic           clock,        // 40 MHz control clock
  input  wire logic           rstn,         // Async reset, active low
  input  wire logic [AW-1:0]  s_awaddr,     // Write address
  input  wire logic           s_awvalid,    // Write address valid
  output logic                s_awready,    // Write address ready
  input  wire logic [31:0]    s_wdata,      // Write data
  input  wire logic [3:0]     s_wstrb,      // Write byte enables
  input  wire logic           s_wvalid,     // Write data valid
  output logic                s_wready,     // Write data ready
  output logic [1:0]          s_bresp,      // Write response
  output logic                s_bvalid,     // Write response valid
  input  wire logic           s_bready,     // Write response ready
  input  wire logic [AW-1:0]  s_araddr,     // Read address
  input  wire logic           s_arvalid,    // Read address valid
  output logic                s_arready,    // Read address ready
  output logic [31:0]         s_rdata,      // Read data
  output logic [1:0]          s_rresp,      // Read response
  output logic                s_rvalid,     // Read data valid
  input  wire logic           s_rready,     // Read data ready
  input  wire logic           energized,    // Motor powered
  input  wire logic           homing_busy,  // Homing run in progress
  input  wire logic           homing_done,  // Homing finished, pulse
  input  wire logic [PW-1:0]  home_pos,     // Detected home position
  input  wire logic [PW-1:0]  pos_set,      // Position setpoint
  input  wire logic [PW-1:0]  pos_act,      // Measured position
  input  wire logic           multiturn,    // Multiturn encoder or emulation
  input  wire logic [PW-1:0]  sensor_dist,  // Home sensor to motor zero distance
  input  wire logic           cmd_valid,    // Motion command, pulse
  input  wire logic [PW-1:0]  cmd_target,   // Target or move distance
  output logic                cmd_accept,   // Command executes, pulse
  output logic                cmd_reject,   // Command blocked, pulse
  output logic [1:0]          react,        // Active error reaction
  output logic                err_pending,  // Limit error awaiting ack
  output logic [15:0]         err_code,     // Last limit error code
  output logic                dir_lock,     // Direction lock engaged
  output logic [PW-1:0]       home_reference, // Positioning reference point
  output logic [8:0]          home_adjust   // Home sensor shift, degrees
);
  // ****************************************
  // Declarations
  // ****************************************
  stlm_cfg_t          cfg_q;
  logic signed [8:0]  adj_q;
  logic [PW-1:0]      hofs_q, lneg_q, lpos_q, win_q, ref_q, rdata_q;
  logic [15:0]        code_q;
  logic               awready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0]         bresp_q, rresp_q, react_q;
  logic               acc_q, rej_q, pend_q, lock_q, lockpos_q, homed_q, armed_q;
  logic               wr_go, rd_go, ack, active, chk;
  logic               over_pos, over_neg, deep_in, tgt_out, toward;
  logic               viol, cmd_err, raise, raise_pos, wr_hit;
  logic signed [PW-1:0] mon_pos, rel_pos, tgt;
  logic [31:0]        wd, ctrl_rd, stat_rd;
  logic [AW-1:0]      wa;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction : wmerge

  // ****************************************
  // AXI4-Lite handshakes
  // ****************************************
  // Ready is raised only once both halves are offered, so they are taken together
  assign wr_go = awready_q & s_awvalid & s_wvalid;
  assign rd_go = arready_q & s_arvalid;
  assign wa    = s_awaddr;

  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      awready_q <= 1'b0;
    else
      awready_q <= s_awvalid & s_wvalid & ~awready_q & ~bvalid_q;

  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OK;
    end
    else if (wr_go)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? RESP_OK : RESP_ERR;
    end
    else if (s_bready)
      bvalid_q <= 1'b0;

  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      arready_q <= 1'b0;
    else
      arready_q <= s_arvalid & ~arready_q & ~rvalid_q;

  always_comb
  begin
    ctrl_rd = 32'h0;
    ctrl_rd[CTRL_REACT_LSB +: 2] = cfg_q.react;
    ctrl_rd[CTRL_EN_BIT]         = cfg_q.err_en;
    ctrl_rd[CTRL_MODE_LSB +: 2]  = cfg_q.mode;
    stat_rd = 32'h0;
    stat_rd[ST_PEND]    = pend_q;
    stat_rd[ST_LOCK]    = lock_q;
    stat_rd[ST_LOCKPOS] = lockpos_q;
    stat_rd[ST_ACTIVE]  = active;
    stat_rd[ST_HOMED]   = homed_q;
  end

  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rresp_q  <= RESP_OK;
    end
    else if (rd_go)
    begin
      rvalid_q <= 1'b1;
      rresp_q  <= RESP_OK;
      case (s_araddr)
        OFS_CTRL: rdata_q <= ctrl_rd;
        OFS_ADJ:  rdata_q <= 32'(adj_q);
        OFS_HOFS: rdata_q <= hofs_q;
        OFS_LNEG: rdata_q <= lneg_q;
        OFS_LPOS: rdata_q <= lpos_q;
        OFS_WIN:  rdata_q <= win_q;
        OFS_STAT: rdata_q <= stat_rd;
        OFS_CODE: rdata_q <= {16'h0, code_q};
        OFS_REF:  rdata_q <= ref_q;
        OFS_DIST: rdata_q <= sensor_dist;
        default:
        begin
          rdata_q <= 32'h0;
          rresp_q <= RESP_ERR;
        end
      endcase
    end
    else if (s_rready)
      rvalid_q <= 1'b0;

  // ****************************************
  // Register writes
  // ****************************************
  always_comb
  begin
    wr_hit = 1'b1;
    wd     = 32'h0;
    case (wa)
      OFS_CTRL: wd = wmerge(ctrl_rd, s_wdata, s_wstrb);
      OFS_ADJ:  wd = wmerge(32'(adj_q), s_wdata, s_wstrb);
      OFS_HOFS: wd = wmerge(hofs_q, s_wdata, s_wstrb);
      OFS_LNEG: wd = wmerge(lneg_q, s_wdata, s_wstrb);
      OFS_LPOS: wd = wmerge(lpos_q, s_wdata, s_wstrb);
      OFS_WIN:  wd = wmerge(win_q, s_wdata, s_wstrb);
      OFS_STAT, OFS_CODE, OFS_REF, OFS_DIST: wd = 32'h0;
      default:  wr_hit = 1'b0;
    endcase
  end

  // Acknowledge is a write-one pulse, it is never stored
  assign ack = wr_go & (wa == OFS_CTRL) & wd[CTRL_ACK_BIT];

  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      cfg_q <= CFG_RST;
    else if (wr_go && wa == OFS_CTRL)
    begin
      cfg_q.react  <= stlm_react_t'(wd[CTRL_REACT_LSB +: 2]);
      cfg_q.err_en <= wd[CTRL_EN_BIT];
      cfg_q.mode   <= stlm_mode_t'(wd[CTRL_MODE_LSB +: 2]);
    end

  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      adj_q <= ADJ_RST;
    else if (wr_go && wa == OFS_ADJ)
    begin
      if ($signed(wd) > $signed(32'(ADJ_MAX)))
        adj_q <= ADJ_MAX;
      else if ($signed(wd) < $signed(32'(ADJ_MIN)))
        adj_q <= ADJ_MIN;
      else
        adj_q <= wd[8:0];
    end

  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      hofs_q <= HOFS_RST;
      lneg_q <= LNEG_RST;
      lpos_q <= LPOS_RST;
      win_q  <= WIN_RST;
    end
    else if (wr_go)
    begin
      if (wa == OFS_HOFS) hofs_q <= wd;
      if (wa == OFS_LNEG) lneg_q <= wd;
      if (wa == OFS_LPOS) lpos_q <= wd;
      if (wa == OFS_WIN)  win_q  <= wd;
    end

  // ****************************************
  // Reference point and activation
  // ****************************************
  // The offset register is only a staging copy until homing completes
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      ref_q   <= 32'h0;
      homed_q <= 1'b0;
    end
    else if (homing_done)
    begin
      ref_q   <= home_pos + hofs_q;
      homed_q <= 1'b1;
    end

  assign active  = (homed_q | multiturn) & ~homing_busy & (cfg_q.mode != MODE_RESET);
  assign chk     = active & cfg_q.err_en;
  assign mon_pos = energized ? pos_set : pos_act;
  assign rel_pos = mon_pos - ref_q;
  assign over_pos = rel_pos > $signed(lpos_q);
  assign over_neg = rel_pos < $signed(lneg_q);
  assign deep_in  = (rel_pos < $signed(lpos_q - win_q)) && (rel_pos > $signed(lneg_q + win_q));

  // ****************************************
  // Command check
  // ****************************************
  always_comb
  begin
    unique case (cfg_q.mode)
      MODE_ABS:   tgt = $signed(cmd_target);
      MODE_RESET: tgt = $signed(cmd_target);
      MODE_CONT:  tgt = rel_pos + $signed(cmd_target);
      default:    tgt = $signed(cmd_target);
    endcase
  end

  assign tgt_out = (tgt > $signed(lpos_q)) || (tgt < $signed(lneg_q));
  assign toward  = lockpos_q ? (tgt < rel_pos) : (tgt > rel_pos);
  assign cmd_err = cmd_valid & chk & ~pend_q & (lock_q ? ~toward : tgt_out);
  assign viol    = chk & armed_q & ~pend_q & ~lock_q & (over_pos | over_neg);
  assign raise   = viol | cmd_err;
  assign raise_pos = lock_q ? lockpos_q : (cmd_err ? (tgt > $signed(lpos_q)) : over_pos);

  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      acc_q <= 1'b0;
      rej_q <= 1'b0;
    end
    else
    begin
      acc_q <= cmd_valid & (~chk | (~pend_q & ~cmd_err));
      rej_q <= cmd_valid & chk & (pend_q | cmd_err);
    end

  // ****************************************
  // Error, reaction, hysteresis, lock
  // ****************************************
  // Set wins over a same-cycle acknowledge so no violation is lost
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      pend_q <= 1'b0;
    else if (raise)
      pend_q <= 1'b1;
    else if (ack)
      pend_q <= 1'b0;

  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      code_q  <= 16'h0;
      react_q <= REACT_NONE;
    end
    else if (raise)
    begin
      code_q  <= raise_pos ? CODE_POS : CODE_NEG;
      react_q <= cfg_q.react;
    end
    else if (ack)
      react_q <= REACT_NONE;

  // Jitter at a limit would re-trigger at once without this re-arm gap
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      armed_q <= 1'b1;
    else if (raise)
      armed_q <= 1'b0;
    else if (deep_in)
      armed_q <= 1'b1;

  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      lock_q    <= 1'b0;
      lockpos_q <= 1'b0;
    end
    else if (ack && pend_q && !raise && (over_pos || over_neg))
    begin
      lock_q    <= 1'b1;
      lockpos_q <= over_pos;
    end
    else if (lock_q && !over_pos && !over_neg)
      lock_q <= 1'b0;

  // ****************************************
  // Outputs
  // ****************************************
  assign s_awready      = awready_q;
  assign s_wready       = awready_q;
  assign s_bvalid       = bvalid_q;
  assign s_bresp        = bresp_q;
  assign s_arready      = arready_q;
  assign s_rvalid       = rvalid_q;
  assign s_rdata        = rdata_q;
  assign s_rresp        = rresp_q;
  assign cmd_accept     = acc_q;
  assign cmd_reject     = rej_q;
  assign react          = react_q;
  assign err_pending    = pend_q;
  assign err_code       = code_q;
  assign dir_lock       = lock_q;
  assign home_reference = ref_q;
  assign home_adjust    = adj_q;

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_lock_away;
    lock_q && cmd_valid && chk && !pend_q && !toward;
  endsequence
  sequence s_err_out;
    cmd_reject && err_pending;
  endsequence
  a_adj_in_range: assert property ($signed(home_adjust) <= ADJ_MAX && $signed(home_adjust) >= ADJ_MIN)
    else $error("home adjust out of range");
  a_ref_on_homing: assert property (homing_done |=> home_reference == $past(home_pos) + $past(hofs_q))
    else $error("reference point not home plus offset");
  a_ref_held: assert property ($changed(home_reference) |-> $past(homing_done))
    else $error("reference changed without homing");
  a_react_on_err: assert property (raise |=> err_pending && react == $past(cfg_q.react))
    else $error("reaction not applied with error");
  a_abs_refused: assert property (cmd_valid && chk && !pend_q && !lock_q && tgt_out |=> s_err_out)
    else $error("out of window target not refused");
  a_reset_mode_free: assert property (cmd_valid && cfg_q.mode == MODE_RESET |=> cmd_accept && !cmd_reject)
    else $error("reset mode command was checked");
  a_hyst_quiet: assert property (!armed_q && !cmd_valid && !pend_q |=> !err_pending)
    else $error("error raised inside hysteresis");
  a_pos_code: assert property (raise && raise_pos |=> err_code == CODE_POS)
    else $error("wrong positive limit code");
  a_neg_code: assert property (raise && !raise_pos |=> err_code == CODE_NEG)
    else $error("wrong negative limit code");
  a_homing_quiet: assert property (homing_busy && !pend_q && !ack |=> !err_pending)
    else $error("monitoring while homing");
  a_disabled_free: assert property (cmd_valid && !cfg_q.err_en |=> cmd_accept)
    else $error("command blocked with errors disabled");
  a_pend_hold: assert property (pend_q && !ack |=> pend_q)
    else $error("pending error dropped without ack");
  a_lock_away: assert property (s_lock_away |=> s_err_out)
    else $error("move away under lock not blocked");
endmodule : stlm_top

`default_nettype wire
